// ---- verilog/itpr_pkg.sv ----
// Constants, offsets, field positions and types of the input timing and pattern RAM block.
// Assumes one converter clock domain plus a serial control clock that runs in frames and also pulses during reset.
package itpr_pkg;
  localparam int DATA_W = 16;
  localparam int RAM_DEPTH = 64;
  localparam int CLK_DIV = 4;
  localparam logic [4:0] ADDR_CFG = 5'h00;
  localparam logic [4:0] ADDR_TIM = 5'h02;
  localparam logic [4:0] ADDR_STAT = 5'h09;
  localparam logic [4:0] ADDR_MEM = 5'h1d;
  localparam logic [4:0] ADDR_TEST = 5'h1e;
  localparam logic [7:0] INSTR_MEM_WR = 8'hee;
  localparam int INSTR_RD_BIT = 7;
  localparam logic [5:0] INSTR_LAST = 6'h07;
  localparam int CFG_LSB_BIT = 6;
  localparam int TIM_DLY_LO = 0;
  localparam int TIM_DLY_HI = 4;
  localparam int TIM_MRG_LO = 7;
  localparam int TIM_MRG_HI = 10;
  localparam int TIM_AUTO_BIT = 11;
  localparam int TIM_DLYEN_BIT = 12;
  localparam int STAT_IRQ_BIT = 0;
  localparam int STAT_TYPE_BIT = 5;
  localparam logic [23:0] TEST_PLAY = 24'h00c000;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [31:0] TIM_RST = 32'h00000000;
  localparam logic [23:0] TEST_RST = 24'h000000;
  localparam logic [4:0] DLY_MAX = 5'h1f;
  localparam logic [4:0] DLY_MIN = 5'h00;
  localparam logic [5:0] LEN_BYTE = 6'h08;
  localparam logic [5:0] LEN_TEST = 6'h18;
  localparam logic [5:0] LEN_WORD = 6'h20;
  typedef enum logic [2:0] {
    ITPR_INSTR = 3'b001,
    ITPR_DATA = 3'b010,
    ITPR_DONE = 3'b100
  } itpr_phase_t;
endpackage

// ---- verilog/itpr_core.sv ----
// Input timing optimizer, serial register port and 64-word pattern memory.
// Assumes early/late margin copies of the data come from analog taps steered by MARGIN_CODE.
`timescale 1ns/1ps
module itpr_core #(
  parameter int DATA_W = itpr_pkg::DATA_W,
  parameter int RAM_DEPTH = itpr_pkg::RAM_DEPTH,
  parameter int CLK_DIV = itpr_pkg::CLK_DIV
) (
  // Converter clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // Serial control port
  input wire logic SCLK,
  input wire logic CS_B,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  // Parallel data and margin copies
  input wire logic [DATA_W-1:0] DATA_I,
  input wire logic [DATA_W-1:0] DATA_Q,
  input wire logic [DATA_W-1:0] EARLY_I,
  input wire logic [DATA_W-1:0] EARLY_Q,
  input wire logic [DATA_W-1:0] LATE_I,
  input wire logic [DATA_W-1:0] LATE_Q,
  // Delay line and data clock
  output logic DATA_CLOCK_OUT,
  output logic DELAY_EN,
  output logic [4:0] CLOCK_DELAY_CODE,
  output logic [3:0] MARGIN_CODE,
  // Status and samples
  output logic TIMING_IRQ,
  output logic ERR_SETUP,
  output logic [DATA_W-1:0] I_OUT,
  output logic [DATA_W-1:0] Q_OUT
);
  import itpr_pkg::*;
  localparam int AW = $clog2(RAM_DEPTH);
  localparam int PW = 6 * DATA_W;

  generate
    if (DATA_W != 16 || RAM_DEPTH < 2 || RAM_DEPTH > 64 || (1 << AW) != RAM_DEPTH
        || CLK_DIV < 2 || CLK_DIV > 256)
    begin : g_bad_cfg
      $error("itpr_core: unsupported parameter values");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [PW-1:0] pin_s1;
    logic [PW-1:0] pin_s2;
    logic [2:0] wr_s;
    logic [1:0] ack_s;
    logic snap_req;
    logic [63:0] snap;
    logic [31:0] tim;
    logic [23:0] test;
    logic irq;
    logic err_setup;
    logic pending;
    logic [7:0] div_cnt;
    logic dclk;
    logic [AW-1:0] pb_addr;
    logic [DATA_W-1:0] i_out;
    logic [DATA_W-1:0] q_out;
    logic dly_en;
    logic [4:0] dly_out;
    logic [3:0] mrg_out;
  } itpr_clk_t;

  typedef struct packed {
    logic [1:0] rst_s;
    logic [1:0] req_s;
    logic ack;
    logic [63:0] mirror;
    logic [7:0] cfg;
    logic wr_tg;
    logic [4:0] wr_addr;
    logic [31:0] wr_data;
    logic [AW-1:0] wr_idx;
  } itpr_ser_t;

  typedef struct packed {
    itpr_phase_t phase;
    logic [7:0] instr;
    logic [5:0] cnt;
    logic [5:0] len;
    logic [4:0] addr;
    logic rd;
    logic mem;
    logic [31:0] sh;
    logic [31:0] out_sh;
    logic [AW-1:0] idx;
    logic [AW:0] words;
    logic sdo;
    logic sdo_oe;
  } itpr_frm_t;

  itpr_clk_t c_ff, nxt_c;
  itpr_ser_t p_ff, nxt_p;
  itpr_frm_t f_ff, nxt_f;
  logic [31:0] ram [RAM_DEPTH];
  logic [31:0] rd_q;

  function automatic logic [5:0] reg_len(input logic [4:0] a);
    if (a == ADDR_TIM || a == ADDR_MEM) return LEN_WORD;
    if (a == ADDR_TEST) return LEN_TEST;
    return LEN_BYTE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock domain
  logic tick, wr_evt, wr_tim, mem_wr, clr_irq, check, setup_e, hold_e, active, step;
  logic [2*DATA_W-1:0] act_d, early_d, late_d;
  logic [4:0] dly;

  always_comb
  begin
    {act_d, early_d, late_d} = c_ff.pin_s2;
    dly = c_ff.tim[TIM_DLY_HI:TIM_DLY_LO];
    tick = c_ff.div_cnt == 8'(CLK_DIV - 1);
    wr_evt = c_ff.wr_s[2] ^ c_ff.wr_s[1];
    wr_tim = wr_evt && p_ff.wr_addr == ADDR_TIM;
    mem_wr = wr_evt && p_ff.wr_addr == ADDR_MEM;
    clr_irq = wr_evt && p_ff.wr_addr == ADDR_STAT && p_ff.wr_data[STAT_IRQ_BIT];
    check = tick && c_ff.pending;
    setup_e = early_d != act_d;
    hold_e = late_d != act_d;
    active = c_ff.test == TEST_PLAY;
    step = check && c_ff.tim[TIM_AUTO_BIT] && (setup_e || hold_e);
    nxt_c = c_ff;
    nxt_c.pin_s1 = {DATA_I, DATA_Q, EARLY_I, EARLY_Q, LATE_I, LATE_Q};
    nxt_c.pin_s2 = c_ff.pin_s1;
    nxt_c.wr_s = {c_ff.wr_s[1:0], p_ff.wr_tg};
    nxt_c.ack_s = {c_ff.ack_s[0], p_ff.ack};
    nxt_c.div_cnt = tick ? 8'h00 : c_ff.div_cnt + 8'h01;
    nxt_c.dclk = nxt_c.div_cnt < 8'(CLK_DIV / 2);
    if (check)
    begin
      nxt_c.pending = 1'b0;
      if (setup_e || hold_e)
        nxt_c.err_setup = setup_e;
    end
    // Only automatic mode may move the code by itself
    if (step && setup_e && dly != DLY_MAX)
      nxt_c.tim[TIM_DLY_HI:TIM_DLY_LO] = dly + 5'h01;
    else if (step && !setup_e && dly != DLY_MIN)
      nxt_c.tim[TIM_DLY_HI:TIM_DLY_LO] = dly - 5'h01;
    if (step || (tick && c_ff.tim[TIM_AUTO_BIT]))
      nxt_c.pending = 1'b1;
    // Software write wins over an optimizer step in the same cycle
    if (wr_tim)
    begin
      nxt_c.tim = p_ff.wr_data;
      if (p_ff.wr_data[TIM_MRG_HI:TIM_DLY_LO] != c_ff.tim[TIM_MRG_HI:TIM_DLY_LO])
        nxt_c.pending = 1'b1;
    end
    if (wr_evt && p_ff.wr_addr == ADDR_TEST)
      nxt_c.test = p_ff.wr_data[23:0];
    // A new error beats a clear arriving in the same cycle
    nxt_c.irq = (c_ff.irq && !clr_irq) || (check && (setup_e || hold_e));
    if (tick)
    begin
      if (!active)
      begin
        nxt_c.i_out = act_d[2*DATA_W-1:DATA_W];
        nxt_c.q_out = act_d[DATA_W-1:0];
      end
      else if (!mem_wr)
      begin
        nxt_c.i_out = rd_q[31:16];
        nxt_c.q_out = rd_q[15:0];
        nxt_c.pb_addr = c_ff.pb_addr + AW'(1);
      end
    end
    if (!active)
      nxt_c.pb_addr = '0;
    // Snapshot for serial readback, reloaded only after the far side acked it
    if (c_ff.ack_s[1] == c_ff.snap_req)
    begin
      nxt_c.snap = {2'b00, c_ff.err_setup, 4'h0, c_ff.irq, c_ff.test, c_ff.tim};
      nxt_c.snap_req = !c_ff.snap_req;
    end
    nxt_c.dly_en = c_ff.tim[TIM_DLYEN_BIT];
    nxt_c.dly_out = c_ff.tim[TIM_DLYEN_BIT] ? dly : DLY_MIN;
    nxt_c.mrg_out = c_ff.tim[TIM_MRG_HI:TIM_MRG_LO];
    if (!RST_B)
    begin
      nxt_c = '0;
      nxt_c.tim = TIM_RST;
      nxt_c.test = TEST_RST;
      nxt_c.pending = 1'b1;
      nxt_c.dclk = 1'b1;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    c_ff <= nxt_c;
  end

  // Separate write and read addresses: serial writes go in at wr_idx while the read continues, playback holds
  always_ff @(posedge CLOCK)
  begin
    if (mem_wr)
      ram[p_ff.wr_idx] <= p_ff.wr_data;
    rd_q <= ram[c_ff.pb_addr];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain; frame state clears whenever the select is high
  logic lsb, fire;
  logic [31:0] fval, rval;

  always_comb
  begin
    lsb = p_ff.cfg[CFG_LSB_BIT];
    fire = 1'b0;
    fval = '0;
    rval = '0;
    nxt_f = f_ff;
    unique case (f_ff.phase)
      ITPR_INSTR:
      begin
        nxt_f.instr = {f_ff.instr[6:0], SDI};
        nxt_f.cnt = f_ff.cnt + 6'h01;
        if (f_ff.cnt == INSTR_LAST)
        begin
          nxt_f.mem = nxt_f.instr == INSTR_MEM_WR;
          nxt_f.rd = nxt_f.instr[INSTR_RD_BIT] && !nxt_f.mem;
          nxt_f.addr = nxt_f.mem ? ADDR_MEM : nxt_f.instr[4:0];
          nxt_f.len = reg_len(nxt_f.addr);
          unique case (nxt_f.addr)
            ADDR_CFG: rval = {24'h000000, p_ff.cfg};
            ADDR_TIM: rval = p_ff.mirror[31:0];
            ADDR_STAT: rval = {24'h000000, p_ff.mirror[63:56]};
            ADDR_TEST: rval = {8'h00, p_ff.mirror[55:32]};
            default: rval = '0;
          endcase
          nxt_f.out_sh = lsb ? rval : rval << (LEN_WORD - nxt_f.len);
          nxt_f.sdo = lsb ? nxt_f.out_sh[0] : nxt_f.out_sh[31];
          nxt_f.sdo_oe = nxt_f.rd;
          nxt_f.cnt = '0;
          nxt_f.sh = '0;
          nxt_f.words = '0;
          nxt_f.idx = lsb ? '0 : AW'(RAM_DEPTH - 1);
          nxt_f.phase = ITPR_DATA;
        end
      end
      ITPR_DATA:
      begin
        nxt_f.sh = lsb ? {SDI, f_ff.sh[31:1]} : {f_ff.sh[30:0], SDI};
        nxt_f.out_sh = lsb ? f_ff.out_sh >> 1 : f_ff.out_sh << 1;
        nxt_f.sdo = lsb ? nxt_f.out_sh[0] : nxt_f.out_sh[31];
        nxt_f.cnt = f_ff.cnt + 6'h01;
        if (f_ff.cnt == f_ff.len - 6'h01)
        begin
          fval = lsb ? nxt_f.sh >> (LEN_WORD - f_ff.len) : nxt_f.sh;
          fire = !f_ff.rd;
          nxt_f.cnt = '0;
          nxt_f.sh = '0;
          nxt_f.phase = ITPR_DONE;
          if (f_ff.mem)
          begin
            nxt_f.idx = lsb ? f_ff.idx + AW'(1) : f_ff.idx - AW'(1);
            nxt_f.words = f_ff.words + (AW + 1)'(1);
            if (f_ff.words != (AW + 1)'(RAM_DEPTH - 1))
              nxt_f.phase = ITPR_DATA;
          end
        end
      end
      ITPR_DONE:
      begin
        nxt_f.sdo_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SCLK or posedge CS_B)
  begin
    if (CS_B)
      f_ff <= '{phase: ITPR_INSTR, default: '0};
    else
      f_ff <= nxt_f;
  end

  always_comb
  begin
    nxt_p = p_ff;
    nxt_p.rst_s = {p_ff.rst_s[0], RST_B};
    nxt_p.req_s = {p_ff.req_s[0], c_ff.snap_req};
    if (p_ff.req_s[1] != p_ff.ack)
    begin
      nxt_p.mirror = c_ff.snap;
      nxt_p.ack = p_ff.req_s[1];
    end
    if (fire && f_ff.addr == ADDR_CFG)
      nxt_p.cfg = fval[7:0];
    else if (fire)
    begin
      nxt_p.wr_tg = !p_ff.wr_tg;
      nxt_p.wr_addr = f_ff.addr;
      nxt_p.wr_data = fval;
      nxt_p.wr_idx = f_ff.idx;
    end
    // Toggle and handshake restart with the converter side, else no write ever crosses
    if (!p_ff.rst_s[1])
    begin
      nxt_p = '0;
      nxt_p.rst_s = {p_ff.rst_s[0], RST_B};
      nxt_p.cfg = CFG_RST;
    end
  end

  always_ff @(posedge SCLK)
  begin
    p_ff <= nxt_p;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign SDO = f_ff.sdo;
  assign SDO_OE = f_ff.sdo_oe;
  assign DATA_CLOCK_OUT = c_ff.dclk;
  assign DELAY_EN = c_ff.dly_en;
  assign CLOCK_DELAY_CODE = c_ff.dly_out;
  assign MARGIN_CODE = c_ff.mrg_out;
  assign TIMING_IRQ = c_ff.irq;
  assign ERR_SETUP = c_ff.err_setup;
  assign I_OUT = c_ff.i_out;
  assign Q_OUT = c_ff.q_out;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_setup_chk;
    check && setup_e && c_ff.tim[TIM_AUTO_BIT] && dly != DLY_MAX && !wr_tim;
  endsequence
  sequence s_hold_chk;
    check && !setup_e && hold_e && c_ff.tim[TIM_AUTO_BIT] && dly != DLY_MIN && !wr_tim;
  endsequence

  a_auto_setup_up: assert property (@(posedge CLOCK) disable iff (!RST_B)
    s_setup_chk |=> dly == $past(dly) + 5'h01) else $error("delay not raised on setup error");
  a_auto_hold_down: assert property (@(posedge CLOCK) disable iff (!RST_B)
    s_hold_chk |=> dly == $past(dly) - 5'h01) else $error("delay not lowered on hold error");
  a_manual_code_kept: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !c_ff.tim[TIM_AUTO_BIT] && !wr_tim |=> $stable(dly)) else $error("manual code changed");
  a_delay_gated: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !c_ff.tim[TIM_DLYEN_BIT] |=> CLOCK_DELAY_CODE == DLY_MIN && !DELAY_EN)
    else $error("delay code out while disabled");
  a_error_irq: assert property (@(posedge CLOCK) disable iff (!RST_B)
    check && (setup_e || hold_e) |=> TIMING_IRQ && ERR_SETUP == $past(setup_e))
    else $error("error did not raise interrupt");
  a_hold_type_low: assert property (@(posedge CLOCK) disable iff (!RST_B)
    check && hold_e && !setup_e |=> !ERR_SETUP) else $error("hold error not typed low");
  a_recheck_armed: assert property (@(posedge CLOCK) disable iff (!RST_B)
    wr_tim && p_ff.wr_data[4:0] != dly |=> c_ff.pending) else $error("change did not rearm check");
  a_write_priority: assert property (@(posedge CLOCK) disable iff (!RST_B)
    tick && active && mem_wr |=> $stable(c_ff.pb_addr)) else $error("playback advanced on write");
  a_play_wrap: assert property (@(posedge CLOCK) disable iff (!RST_B)
    tick && active && !mem_wr && c_ff.pb_addr == AW'(RAM_DEPTH - 1) |=> c_ff.pb_addr == '0)
    else $error("playback did not wrap");
  a_pin_source: assert property (@(posedge CLOCK) disable iff (!RST_B)
    tick && !active |=> I_OUT == $past(act_d[2*DATA_W-1:DATA_W])) else $error("pins not used");
endmodule // itpr_core

// ---- sim/itpr_src.sv ----
// Baseband data source model feeding the parallel pins and margin copies.
// Assumes the bench commands the error mode; 0 clean, 1 early copy wrong, 2 late copy wrong.
`timescale 1ns/1ps
module itpr_src (
  // Clock and commands
  input wire logic clock,
  input wire logic [1:0] mode,
  input wire logic [15:0] level,
  // Samples and margin copies
  output logic [15:0] data_i,
  output logic [15:0] data_q,
  output logic [15:0] early_i,
  output logic [15:0] early_q,
  output logic [15:0] late_i,
  output logic [15:0] late_q
);
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {data_i, data_q, early_i, early_q, late_i, late_q} = '0;
  end
  // Copies disagree only when commanded, so any error seen is a real one
  always @(posedge clock)
  begin
    data_i <= level;
    data_q <= ~level;
    early_i <= (mode == 2'h1) ? ~level : level;
    early_q <= ~level;
    late_i <= (mode == 2'h2) ? ~level : level;
    late_q <= ~level;
  end
endmodule // itpr_src

// ---- sim/input_timing_and_pattern_ram_tb.sv ----
// Self-checking bench: serial host tasks, timing checker and pattern memory tests.
// Assumes itpr_pkg and itpr_core are compiled first; serial clock runs in frames, plus four pulses during reset.
`timescale 1ns/1ps
module input_timing_and_pattern_ram_tb;
  import itpr_pkg::*;
  logic CLOCK = 1'b0;
  logic RST_B = 1'b0;
  logic SCLK = 1'b0;
  logic CS_B = 1'b1;
  logic SDI = 1'b0;
  logic SDO, SDO_OE, DATA_CLOCK_OUT, DELAY_EN, TIMING_IRQ, ERR_SETUP;
  logic [4:0] CLOCK_DELAY_CODE;
  logic [3:0] MARGIN_CODE;
  logic [15:0] DATA_I, DATA_Q, EARLY_I, EARLY_Q, LATE_I, LATE_Q, I_OUT, Q_OUT;
  logic [1:0] err_mode = 2'h0;
  logic [15:0] level = 16'h0000;
  logic lsb = 1'b0;
  logic [31:0] rd;
  int err_total = 0;
  int n_compared = 0;
  int dclk_hi = 0;
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #2 CLOCK = ~CLOCK;
  end
  itpr_src u_src (.clock(CLOCK), .mode(err_mode), .level(level), .data_i(DATA_I),
    .data_q(DATA_Q), .early_i(EARLY_I), .early_q(EARLY_Q), .late_i(LATE_I), .late_q(LATE_Q));
  itpr_core u_dut (.CLOCK(CLOCK), .RST_B(RST_B), .SCLK(SCLK), .CS_B(CS_B), .SDI(SDI),
    .SDO(SDO), .SDO_OE(SDO_OE), .DATA_I(DATA_I), .DATA_Q(DATA_Q), .EARLY_I(EARLY_I),
    .EARLY_Q(EARLY_Q), .LATE_I(LATE_I), .LATE_Q(LATE_Q), .DATA_CLOCK_OUT(DATA_CLOCK_OUT),
    .DELAY_EN(DELAY_EN), .CLOCK_DELAY_CODE(CLOCK_DELAY_CODE), .MARGIN_CODE(MARGIN_CODE),
    .TIMING_IRQ(TIMING_IRQ), .ERR_SETUP(ERR_SETUP), .I_OUT(I_OUT), .Q_OUT(Q_OUT));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Data set up half a period before the rising edge
  task automatic sbit(input logic b, output logic o);
    SDI <= b;
    #32;
    o = SDO;
    SCLK <= 1'b1;
    #32;
    SCLK <= 1'b0;
  endtask
  // Odd start offset keeps serial edges off the converter clock grid
  task automatic start(input logic [7:0] ins);
    logic o;
    CS_B <= 1'b0;
    #33;
    for (int i = 0; i < 8; i++)
      sbit(ins[7-i], o);
  endtask
  // Generous wait covers the crossing into the converter domain
  task automatic fin();
    #32;
    CS_B <= 1'b1;
    repeat (20) @(posedge CLOCK);
  endtask
  task automatic xfer(input logic [7:0] ins, input logic [31:0] wd, input int nb);
    logic o;
    rd = 32'h0;
    start(ins);
    chk(SDO_OE, ins[7]);
    for (int i = 0; i < nb; i++)
    begin
      sbit(wd[lsb ? i : nb-1-i], o);
      rd[lsb ? i : nb-1-i] = o;
    end
    fin();
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input int nb);
    xfer({3'h0, a}, d, nb);
  endtask
  task automatic rdr(input logic [4:0] a, input int nb);
    xfer({3'h4, a}, 32'h0, nb);
  endtask
  // Word content encodes its own address, so order faults show in playback
  task automatic load(input logic [15:0] ib, input logic [15:0] qb);
    logic o;
    logic [31:0] w;
    logic [5:0] a;
    start(INSTR_MEM_WR);
    for (int k = 0; k < RAM_DEPTH; k++)
    begin
      a = lsb ? 6'(k) : 6'(RAM_DEPTH-1-k);
      w = {ib + 16'(a), qb + 16'(a)};
      for (int i = 0; i < 32; i++)
        sbit(w[lsb ? i : 31-i], o);
    end
    fin();
  endtask
  task automatic play(input logic [15:0] ib, input logic [15:0] qb);
    logic [15:0] last;
    int t;
    last = I_OUT;
    for (int n = 0; n < 70; n++)
    begin
      t = 0;
      while (I_OUT === last && t < 20)
      begin
        @(negedge CLOCK);
        t++;
      end
      chk(Q_OUT, qb + (I_OUT - ib));
      chk(I_OUT[15:6], ib[15:6]);
      if (n > 0)
        chk(I_OUT[5:0], 6'(last[5:0] + 6'h01));
      last = I_OUT;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #390000;
    err_total++;
    $display("watchdog expired");
    conclude();
  end
  initial
  begin
    // Serial domain needs its own edges to see reset
    repeat (4)
    begin
      #32 SCLK <= 1'b1;
      #32 SCLK <= 1'b0;
    end
    repeat (16) @(posedge CLOCK);
    RST_B <= 1'b1;
    repeat (20) @(posedge CLOCK);
    chk(DELAY_EN, 1'b0);
    chk(CLOCK_DELAY_CODE, 5'h00);
    // Data clock high for half of every sample period
    repeat (2 * CLK_DIV)
    begin
      @(negedge CLOCK);
      dclk_hi += DATA_CLOCK_OUT;
    end
    chk(dclk_hi, CLK_DIV);
    rdr(ADDR_TIM, 32);
    chk(rd, TIM_RST);
    rdr(ADDR_CFG, 8);
    chk(rd, CFG_RST);
    rdr(5'h05, 8);
    chk(rd, 32'h0);
    $display("test reset done");
    wr(ADDR_TIM, 32'h00000005, 32);
    chk(CLOCK_DELAY_CODE, 5'h00);
    err_mode <= 2'h1;
    wr(ADDR_TIM, 32'h00001185, 32);
    chk(CLOCK_DELAY_CODE, 5'h05);
    chk(MARGIN_CODE, 4'h3);
    chk(TIMING_IRQ, 1'b1);
    chk(ERR_SETUP, 1'b1);
    rdr(ADDR_STAT, 8);
    chk(rd, 32'(1 << STAT_TYPE_BIT | 1 << STAT_IRQ_BIT));
    wr(ADDR_STAT, 32'h01, 8);
    repeat (100) @(posedge CLOCK);
    chk(TIMING_IRQ, 1'b0);
    chk(CLOCK_DELAY_CODE, 5'h05);
    err_mode <= 2'h2;
    wr(ADDR_TIM, 32'h00001205, 32);
    chk(TIMING_IRQ, 1'b1);
    chk(ERR_SETUP, 1'b0);
    rdr(ADDR_STAT, 8);
    chk(rd, 32'(1 << STAT_IRQ_BIT));
    $display("test manual done");
    err_mode <= 2'h1;
    wr(ADDR_TIM, 32'h0000180a, 32);
    repeat (200) @(posedge CLOCK);
    chk(CLOCK_DELAY_CODE, DLY_MAX);
    rdr(ADDR_TIM, 32);
    chk(rd[4:0], DLY_MAX);
    err_mode <= 2'h2;
    repeat (200) @(posedge CLOCK);
    chk(CLOCK_DELAY_CODE, DLY_MIN);
    rdr(ADDR_TIM, 32);
    chk(rd[4:0], DLY_MIN);
    err_mode <= 2'h0;
    wr(ADDR_TIM, 32'h00001005, 32);
    $display("test auto done");
    level <= 16'h1234;
    repeat (20) @(posedge CLOCK);
    chk(I_OUT, 16'h1234);
    chk(Q_OUT, 16'hedcb);
    load(16'ha000, 16'h5000);
    wr(ADDR_TEST, TEST_PLAY, 24);
    play(16'ha000, 16'h5000);
    rdr(ADDR_TEST, 24);
    chk(rd, TEST_PLAY);
    $display("test msb load done");
    wr(ADDR_CFG, 32'h40, 8);
    lsb = 1'b1;
    rdr(ADDR_CFG, 8);
    chk(rd, 32'h40);
    load(16'hc000, 16'h3000);
    play(16'hc000, 16'h3000);
    wr(ADDR_TEST, 32'h0, 24);
    chk(I_OUT, 16'h1234);
    $display("test lsb load done");
    conclude();
  end
endmodule // input_timing_and_pattern_ram_tb
